// ==== logic/mcg_clock_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_gen
   import mcg_pkg::*;
#(
   // oscillator synchroniser depth
   parameter int OSC_SYNC_STAGES = SYNC_STAGES
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [BE_W-1:0]   byteenable,
   input  wire logic [DATA_W-1:0] writedata,
   output var  logic [DATA_W-1:0] readdata,
   output var  logic              waitrequest,
   // oscillator pin
   input  wire logic              oscillator_input_pin,
   // derived clocks
   output var  logic              master_clk,
   output var  logic              cpu_clk,
   output var  logic              sys_clk,
   // analog pll controls
   output var  logic              pll_enable,
   output var  logic [BAND_W-1:0] vco_band_field
);
   // ---------------- elaboration checks ----------------
   if (OSC_SYNC_STAGES < 2) begin : g_bad_sync
      $error("oscillator synchroniser needs at least two stages");
   end
   // slowest bypass divide must fit the divider counter
   if ((int'(IDIV_MAX) + 1) * (int'(ODIV_MAX) + 1) >= (1 << DIV_W)) begin : g_bad_div
      $error("divider counter too narrow for the largest prescale product");
   end
   // one full pll step plus a remainder must fit the accumulator
   if ((2 << MUL_W) + (1 << DIV_W) > (1 << ACC_W)) begin : g_bad_acc
      $error("pll accumulator too narrow");
   end
   // status layout must not overlap its flag bits
   if (ST_CFG_LSB + CFG_W > ST_HALVE) begin : g_bad_stat
      $error("status fields overlap");
   end
   // control fields must fit a bus word
   if (MUL_LSB + MUL_W > DATA_W) begin : g_bad_ctrl
      $error("control fields exceed the data width");
   end

   // ---------------- bus slave ----------------
   logic              ack_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] wmask;
   logic              req;
   logic              wr_take;
   logic              hit_ctrl;
   logic              hit_sysc;
   logic              hit_stat;

   assign req         = read | write;
   assign waitrequest = req & ~ack_ff;
   // a write lands at the edge where waitrequest is low
   assign wr_take     = write & ack_ff;
   assign hit_ctrl    = (address == CTRL_OFF);
   assign hit_sysc    = (address == SYSC_OFF);
   assign hit_stat    = (address == STAT_OFF);
   assign readdata    = rdata_ff;

   for (genvar b = 0; b < BE_W; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{byteenable[b]}};
   end

   // ---------------- software registers ----------------
   mcg_cfg_t  sh_cfg_ff;
   mcg_cfg_t  act_cfg_ff;
   logic      sh_halve_ff;
   logic      act_halve_ff;
   mcg_cfg_t  wr_cfg;
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] ctrl_merged;
   logic [ODIV_W-1:0] wr_odiv;
   logic [BAND_W-1:0] wr_band;
   logic      pend;

   assign ctrl_word = {{(DATA_W-MUL_LSB-MUL_W){1'b0}}, sh_cfg_ff.mul, sh_cfg_ff.odiv,
                       sh_cfg_ff.idiv, sh_cfg_ff.band, sh_cfg_ff.src};
   assign ctrl_merged = (writedata & wmask) | (ctrl_word & ~wmask);
   // output prescale values above 14 are clamped
   assign wr_odiv = (ctrl_merged[ODIV_LSB +: ODIV_W] > ODIV_MAX) ?
                    ODIV_MAX : ctrl_merged[ODIV_LSB +: ODIV_W];
   // reserved band code keeps the previous band
   assign wr_band = (ctrl_merged[BAND_LSB +: BAND_W] == BAND_RSVD) ?
                    sh_cfg_ff.band : ctrl_merged[BAND_LSB +: BAND_W];
   assign wr_cfg.src  = ctrl_merged[SRC_LSB +: SRC_W];
   assign wr_cfg.band = wr_band;
   assign wr_cfg.idiv = ctrl_merged[IDIV_LSB +: IDIV_W];
   assign wr_cfg.odiv = wr_odiv;
   assign wr_cfg.mul  = ctrl_merged[MUL_LSB +: MUL_W];
   assign pend = (sh_cfg_ff != act_cfg_ff) | (sh_halve_ff != act_halve_ff);

   always_comb begin
      nxt_rdata = '0;
      if (hit_ctrl) begin
         nxt_rdata = ctrl_word;
      end else if (hit_sysc) begin
         nxt_rdata[HALVE_BIT] = sh_halve_ff;
      end else if (hit_stat) begin
         nxt_rdata[ST_CFG_LSB +: CFG_W] = act_cfg_ff;
         nxt_rdata[ST_HALVE] = act_halve_ff;
         nxt_rdata[ST_MC]    = master_clk;
         nxt_rdata[ST_CPU]   = cpu_clk;
         nxt_rdata[ST_PEND]  = pend;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (read & ~ack_ff) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sh_cfg_ff   <= CFG_RST;
         sh_halve_ff <= HALVE_RST;
      end else begin
         if (wr_take & hit_ctrl) begin
            sh_cfg_ff <= wr_cfg;
         end
         if (wr_take & hit_sysc & byteenable[0]) begin
            sh_halve_ff <= writedata[HALVE_BIT];
         end
      end
   end

   // ---------------- oscillator sampling ----------------
   logic osc_s;
   logic osc_d_ff;
   logic osc_rise;

   mcg_sync #(.STAGES(OSC_SYNC_STAGES)) u_osc_sync (
      .clock (clock),
      .rst   (rst),
      .din   (oscillator_input_pin),
      .dout  (osc_s)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         osc_d_ff <= 1'b0;
      end else begin
         osc_d_ff <= osc_s;
      end
   end

   assign osc_rise = osc_s & ~osc_d_ff;

   // ---------------- master clock generation ----------------
   logic [DIV_W-1:0] div_n;
   logic [DIV_W-1:0] half_hi;
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W-1:0] nxt_acc;
   logic [ACC_W-1:0] acc_add;
   logic [ACC_W-1:0] acc_sum;
   logic             mc_ff;
   logic             nxt_mc;
   logic             is_pll;
   logic             passthru;
   logic             acc_ovf;
   logic             mc_rise;
   logic [DIV_W-1:0] idiv_fac;
   logic [DIV_W-1:0] odiv_fac;
   logic [ACC_W:0]   acc_wide;
   logic             hold_ff;
   logic             nxt_hold;
   logic             leave_pll;
   logic             cfg_chg;

   assign is_pll    = (act_cfg_ff.src == SRC_PLL);
   assign idiv_fac  = DIV_W'(act_cfg_ff.idiv) + DIV_W'(1);
   assign odiv_fac  = DIV_W'(act_cfg_ff.odiv) + DIV_W'(1);
   // product of both prescale factors, at most 4 x 15 = 60
   assign div_n     = DIV_W'(idiv_fac * odiv_fac);
   assign half_hi   = DIV_W'(({1'b0, div_n} + 7'd1) >> 1);
   assign passthru  = ~is_pll & (div_n == DIV_W'(1));
   // pll: each oscillator rise adds two half periods per multiply step
   assign acc_add   = osc_rise ? ACC_W'({act_cfg_ff.mul, 1'b0} + 7'd2) : '0;
   // saturate so an unreachable rate keeps toggling instead of wrapping
   assign acc_wide  = {1'b0, acc_ff} + {1'b0, acc_add};
   assign acc_sum   = acc_wide[ACC_W] ? '1 : acc_wide[ACC_W-1:0];
   assign acc_ovf   = (acc_sum >= ACC_W'(div_n));
   // applied setup differs from the written one
   assign cfg_chg   = (sh_cfg_ff != act_cfg_ff);
   // leaving the pll lands at a rise unrelated to the oscillator phase
   assign leave_pll = is_pll & (sh_cfg_ff.src != SRC_PLL);
   assign nxt_hold  = mc_rise ? leave_pll : (hold_ff & ~osc_rise);

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_acc = acc_ff;
      nxt_mc  = mc_ff;
      if (is_pll) begin
         nxt_acc = acc_sum;
         if (acc_ovf) begin
            nxt_acc = acc_sum - ACC_W'(div_n);
            nxt_mc  = ~mc_ff;
         end
      end else if (hold_ff) begin
         // keep the fresh high phase until the oscillator next rises
         nxt_mc = mc_ff;
      end else if (passthru) begin
         nxt_mc = osc_s;
      end else if (osc_rise) begin
         nxt_cnt = (cnt_ff == div_n - DIV_W'(1)) ? '0 : cnt_ff + DIV_W'(1);
         nxt_mc  = (nxt_cnt < half_hi);
      end
   end

   assign mc_rise = nxt_mc & ~mc_ff;

   // new setup applied only where a master period starts, so no runt
   always_ff @(posedge clock) begin
      if (rst) begin
         act_cfg_ff <= CFG_RST;
         cnt_ff     <= '0;
         acc_ff     <= '0;
         mc_ff      <= 1'b0;
      end else begin
         mc_ff <= nxt_mc;
         if (mc_rise) begin
            act_cfg_ff <= sh_cfg_ff;
            cnt_ff     <= '0;
            // keep the pll remainder unless the setup changes
            acc_ff     <= cfg_chg ? '0 : nxt_acc;
         end else begin
            cnt_ff <= nxt_cnt;
            acc_ff <= nxt_acc;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hold_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   // ---------------- cpu and system clocks ----------------
   logic cpu_ff;
   logic sys_ff;
   logic nxt_cpu;
   logic cpu_load;
   logic halve_eff;

   // halve bit taken only where a cpu period begins
   assign cpu_load  = mc_rise & ~cpu_ff;
   assign halve_eff = cpu_load ? sh_halve_ff : act_halve_ff;
   // full rate follows the next master level so both flops switch together
   assign nxt_cpu   = halve_eff ? (mc_rise ? ~cpu_ff : cpu_ff) : nxt_mc;

   always_ff @(posedge clock) begin
      if (rst) begin
         act_halve_ff <= HALVE_RST;
         cpu_ff       <= 1'b0;
         sys_ff       <= 1'b0;
      end else begin
         act_halve_ff <= halve_eff;
         cpu_ff       <= nxt_cpu;
         // peripheral clock is its own flop on the same edges as the cpu clock
         sys_ff       <= nxt_cpu;
      end
   end

   assign master_clk     = mc_ff;
   assign cpu_clk        = cpu_ff;
   assign sys_clk        = sys_ff;
   assign pll_enable     = is_pll;
   assign vco_band_field = act_cfg_ff.band;
endmodule // mcg_clock_gen
`default_nettype wire

// ==== logic/mcg_pkg.sv ====
`default_nettype none
package mcg_pkg;
   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   // register byte offsets
   localparam logic [3:0] CTRL_OFF   = 4'h0;
   localparam logic [3:0] SYSC_OFF   = 4'h4;
   localparam logic [3:0] STAT_OFF   = 4'h8;
   // clock_gen_control field positions
   localparam int SRC_LSB   = 0;
   localparam int BAND_LSB  = 2;
   localparam int IDIV_LSB  = 4;
   localparam int ODIV_LSB  = 6;
   localparam int MUL_LSB   = 10;
   localparam int SRC_W     = 2;
   localparam int BAND_W    = 2;
   localparam int IDIV_W    = 2;
   localparam int ODIV_W    = 4;
   localparam int MUL_W     = 5;
   // system_control_one field positions
   localparam int HALVE_BIT = 0;
   // status field positions
   localparam int ST_CFG_LSB = 0;
   localparam int ST_HALVE   = 16;
   localparam int ST_MC      = 17;
   localparam int ST_CPU     = 18;
   localparam int ST_PEND    = 19;
   // field limits and codes
   localparam logic [IDIV_W-1:0] IDIV_MAX  = 2'h3;
   localparam logic [ODIV_W-1:0] ODIV_MAX  = 4'he;
   localparam logic [SRC_W-1:0]  SRC_PLL   = 2'h3;
   localparam logic [BAND_W-1:0] BAND_RSVD = 2'h3;
   localparam logic [BAND_W-1:0] BAND_LO   = 2'h0;
   localparam logic [BAND_W-1:0] BAND_MID  = 2'h1;
   localparam logic [BAND_W-1:0] BAND_HI   = 2'h2;
   // divider arithmetic widths
   localparam int DIV_W = 6;
   localparam int ACC_W = 8;
   // reset values
   localparam logic [SRC_W-1:0]  SRC_RST   = 2'h0;
   localparam logic [BAND_W-1:0] BAND_RST  = 2'h0;
   localparam logic [IDIV_W-1:0] IDIV_RST  = 2'h0;
   localparam logic [ODIV_W-1:0] ODIV_RST  = 4'h0;
   localparam logic [MUL_W-1:0]  MUL_RST   = 5'h00;
   localparam logic              HALVE_RST = 1'b0;
   // timing
   localparam int CLK_HZ      = 20_000_000;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic [MUL_W-1:0]  mul;
      logic [ODIV_W-1:0] odiv;
      logic [IDIV_W-1:0] idiv;
      logic [BAND_W-1:0] band;
      logic [SRC_W-1:0]  src;
   } mcg_cfg_t;

   localparam int CFG_W = $bits(mcg_cfg_t);
   localparam mcg_cfg_t CFG_RST = '{mul: MUL_RST, odiv: ODIV_RST, idiv: IDIV_RST,
                                    band: BAND_RST, src: SRC_RST};
endpackage
`default_nettype wire

// ==== logic/mcg_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcg_sync
   import mcg_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // level in and out
   input  wire logic din,
   output var  logic dout
);
   logic [STAGES-1:0] chain_ff;

   if (STAGES < 2) begin : g_bad_stages
      $error("mcg_sync needs at least two stages");
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         chain_ff <= '0;
      end else begin
         chain_ff <= {chain_ff[STAGES-2:0], din};
      end
   end

   assign dout = chain_ff[STAGES-1];
endmodule // mcg_sync
`default_nettype wire

// ==== tb/mcg_clock_gen_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_gen_assertions
   import mcg_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              rst,
   // bus
   input wire logic              read,
   input wire logic              write,
   input wire logic              waitrequest,
   // derived clocks and pll controls
   input wire logic              master_clk,
   input wire logic              cpu_clk,
   input wire logic              sys_clk,
   input wire logic              pll_enable,
   input wire logic [BAND_W-1:0] vco_band_field
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_SYS_EQ_CPU: assert property (sys_clk == cpu_clk)
      else $error("sys clock differs from cpu clock");
   AST_CPU_CHG: assert property ($changed(cpu_clk) |-> $changed(master_clk))
      else $error("cpu clock moved without master edge");
   AST_CPU_RISE: assert property ($rose(cpu_clk) |-> $rose(master_clk))
      else $error("cpu clock rose off master rise");
   AST_BAND_OK: assert property (vco_band_field != BAND_RSVD)
      else $error("reserved vco band active");
   AST_CFG_AT_RISE: assert property ($changed(vco_band_field) || $changed(pll_enable)
      |-> master_clk || $past(master_clk))
      else $error("config applied away from master rise");
   AST_NO_RUNT: assert property (!pll_enable && $changed(master_clk)
      |=> $stable(master_clk) || pll_enable)
      else $error("runt pulse on master clock");
   AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait");
   AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest without request");
   COV_PLL: cover property ($rose(pll_enable));
   COV_HALF: cover property ($rose(master_clk) && !$rose(cpu_clk));
   COV_BUS: cover property (write && !waitrequest);
endmodule // mcg_clock_gen_assertions
bind mcg_clock_gen mcg_clock_gen_assertions u_chk (.clock(clock), .rst(rst), .read(read),
   .write(write), .waitrequest(waitrequest), .master_clk(master_clk), .cpu_clk(cpu_clk),
   .sys_clk(sys_clk), .pll_enable(pll_enable), .vco_band_field(vco_band_field));
`default_nettype wire

// ==== tb/mcg_clock_gen_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_gen_bench
   import mcg_pkg::*;
;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic [BE_W-1:0]   byteenable = 4'hf;
   logic [DATA_W-1:0] writedata = '0;
   logic [DATA_W-1:0] readdata, rd;
   logic              waitrequest, osc, master_clk, cpu_clk, sys_clk, pll_enable;
   logic [BAND_W-1:0] vco_band_field;
   logic [7:0]        half = 8'h02;
   int                bad_count = 0;
   int                checks = 0;
   int                cyc = 0;
   int                len;
   always #25 clock = ~clock;
   mcg_osc u_osc (.clock(clock), .half(half), .osc(osc));
   mcg_clock_gen dut (.clock(clock), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .oscillator_input_pin(osc), .master_clk(master_clk),
      .cpu_clk(cpu_clk), .sys_clk(sys_clk), .pll_enable(pll_enable),
      .vco_band_field(vco_band_field));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wcfg(input logic [1:0] s, b, i, input logic [3:0] o, input logic [4:0] m);
      mcg_cfg_t c;
      c = '{mul: m, odiv: o, idiv: i, band: b, src: s};
      bus(1'b1, CTRL_OFF, DATA_W'(c));
   endtask
   // cycles from one rise of the picked clock to the n-th rise after it
   task automatic per(input int s, input int n, output int l);
      logic p;
      int   k;
      p = 1'b1;
      k = -1;
      l = 0;
      while (k < n && l < 4000) begin
         @(negedge clock);
         if (k >= 0)
            l++;
         if ((s == 0 ? master_clk : s == 1 ? cpu_clk : sys_clk) === 1'b1 && p === 1'b0)
            k++;
         p = (s == 0) ? master_clk : (s == 1) ? cpu_clk : sys_clk;
      end
   endtask
   task automatic t_reset();
      bus(1'b0, CTRL_OFF, 32'h0);
      cmp("ctrl reset", 32'h0, rd);
      bus(1'b0, SYSC_OFF, 32'h0);
      cmp("sysc reset", 32'h0, rd);
      bus(1'b0, 4'hc, 32'h0);
      cmp("unmapped", 32'h0, rd);
      bus(1'b0, STAT_OFF, 32'h0);
      cmp("status reset", 32'h0, rd & 32'h0009_7fff);
      $display("test reset done");
   endtask
   task automatic t_bypass();
      int i [5] = '{0, 1, 0, 2, 3};
      int o [5] = '{0, 0, 2, 1, 14};
      for (int t = 0; t < 5; t++) begin
         wcfg(2'(t % 3), 2'h0, 2'(i[t]), 4'(o[t]), 5'h1f);
         per(0, 2, len);
         per(0, 2, len);
         cmp("bypass period", 32'(2 * (i[t] + 1) * (o[t] + 1) * 4), 32'(len));
      end
      wcfg(2'h0, 2'h0, 2'h0, 4'hf, 5'h00);
      bus(1'b0, CTRL_OFF, 32'h0);
      cmp("odiv clamp", 32'(ODIV_MAX), 32'(rd[ODIV_LSB+:ODIV_W]));
      bus(1'b0, STAT_OFF, 32'h0);
      cmp("pending", 32'h1, 32'(rd[ST_PEND]));
      $display("test bypass done");
   endtask
   task automatic t_pll();
      int e [4] = '{32, 128, 32, 32};
      logic [3:0] o [4] = '{4'h1, 4'h0, 4'h0, 4'h1};
      logic [4:0] m [4] = '{5'h03, 5'h00, 5'h01, 5'h03};
      half <= 8'h08;
      for (int t = 0; t < 4; t++) begin
         wcfg(SRC_PLL, 2'(t), 2'(t == 1), o[t], m[t]);
         per(0, 2, len);
         per(0, 4, len);
         cmp("pll period", 32'(e[t]), 32'(len));
         cmp("pll enable", 32'h1, 32'(pll_enable));
         cmp("vco band", (t == 3) ? 32'h2 : 32'(t), 32'(vco_band_field));
      end
      half <= 8'h02;
      wcfg(2'h0, 2'h0, 2'h1, 4'h0, 5'h00);
      per(0, 2, len);
      cmp("pll off", 32'h0, 32'(pll_enable));
      $display("test pll done");
   endtask
   task automatic t_halve();
      bus(1'b1, SYSC_OFF, 32'h1);
      per(1, 2, len);
      per(1, 2, len);
      cmp("cpu halved", 32'd32, 32'(len));
      per(2, 2, len);
      cmp("sys period", 32'd32, 32'(len));
      bus(1'b0, SYSC_OFF, 32'h0);
      cmp("sysc readback", 32'h1, rd);
      bus(1'b1, SYSC_OFF, 32'h0);
      per(1, 2, len);
      per(1, 2, len);
      cmp("cpu full", 32'd16, 32'(len));
      bus(1'b0, STAT_OFF, 32'h0);
      cmp("status active", 32'h1 << IDIV_LSB, rd & 32'h0009_7fff);
      $display("test halve done");
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_bypass();
      t_pll();
      t_halve();
      end_sim();
   end
endmodule // mcg_clock_gen_bench
`default_nettype wire

// ==== tb/mcg_osc.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcg_osc (
   // system clock
   input  wire logic       clock,
   // half period in clocks
   input  wire logic [7:0] half,
   // oscillator level, free running
   output var  logic       osc
);
   logic [7:0] cnt_ff = 8'h00;
   initial osc = 1'b0;
   always @(posedge clock) begin
      cnt_ff <= (cnt_ff + 8'h01 >= half) ? 8'h00 : cnt_ff + 8'h01;
      if (cnt_ff + 8'h01 >= half)
         osc <= ~osc;
   end
endmodule // mcg_osc
`default_nettype wire
